// >>> logic/ansc_autoneg_bank.sv
// Auto-negotiation status and counter register bank.
// Assumes a synchronous 16-bit register port and event pulses in clk domain.
`timescale 1ns/1ns
`include "ansc_defs.svh"
module ansc_autoneg_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    input wire ansc_pkg::ansc_req_s req,
    input wire ansc_pkg::ansc_neg_s neg,
    input wire logic page_valid,
    input wire logic [15:0] page_word,
    input wire logic disconnect_event,
    input wire logic false_carrier_event,
    output logic [15:0] rdata_q,
    output logic rvalid_q,
    output logic [15:0] advert_q
);
    // -------------------------------------------------
    // Address decode
    // -------------------------------------------------
    wire hit_adv = req.addr == `ANSC_OFF_ADVERT;
    wire hit_par = req.addr == `ANSC_OFF_PARTNER;
    wire hit_exp = req.addr == `ANSC_OFF_EXPAN;
    wire hit_dis = req.addr == `ANSC_OFF_DISC;
    wire hit_fca = req.addr == `ANSC_OFF_FCAR;
    wire rd_par = req.rd && hit_par;
    wire rd_dis = req.rd && hit_dis;
    wire rd_fca = req.rd && hit_fca;
    // Any mapped offset; used by the unmapped-read check
    wire hit_any = hit_adv || hit_par || hit_exp || hit_dis || hit_fca;

    // Stored state
    logic [15:0] adv_store_q; // Writable advert bits; reset also loads pause bit 10
    logic [15:0] partner_q;   // Latest partner page
    logic page_rx_q;          // New page flag
    logic [15:0] disconnect_count_value;
    logic [15:0] false_carrier_count_value;

    // -------------------------------------------------
    // Composed views
    // -------------------------------------------------
    // Next page and acknowledge bits come live from the engine; pause is tied high
    logic [15:0] adv_view;
    always_comb begin
        adv_view = adv_store_q & `ANSC_ADVERT_WMASK;
        adv_view[`ANSC_BIT_NP] = neg.next_page_flag;
        adv_view[`ANSC_BIT_ACK] = neg.ack_sent;
        adv_view[`ANSC_BIT_PAUSE] = 1'b1;
    end
    // Upper expansion bits forced zero
    logic [15:0] exp_view;
    assign exp_view = {11'h000, neg.multiple_link_fault,
        neg.partner_next_page_capable,
        neg.local_next_page_capable,
        page_rx_q, neg.partner_negotiation_capable} & `ANSC_EXPAN_MASK;

    // Read mux; unmapped offsets answer zero
    logic [15:0] rdata_d;
    assign rdata_d = hit_adv ? adv_view :
                     hit_par ? partner_q :
                     hit_exp ? exp_view :
                     hit_dis ? disconnect_count_value :
                     hit_fca ? false_carrier_count_value : 16'h0000;

    // -------------------------------------------------
    // Advertisement and partner words
    // -------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            adv_store_q <= `ANSC_ADVERT_RST;
            partner_q <= `ANSC_PARTNER_RST;
        end else begin
            // Only writable positions take host data
            if (req.wr && hit_adv) begin
                adv_store_q <= req.wdata & `ANSC_ADVERT_WMASK;
            end
            // Each received page replaces partner word
            if (page_valid) begin
                partner_q <= page_word;
            end
        end
    end

    // -------------------------------------------------
    // Page-received flag: set wins over read clear
    // -------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            page_rx_q <= 1'b0;
        end else if (page_valid) begin
            page_rx_q <= 1'b1;
        end else if (rd_par) begin
            page_rx_q <= 1'b0;
        end
    end

    // -------------------------------------------------
    // Read data register, old counter value returned
    // -------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
            advert_q <= `ANSC_ADVERT_RST;
        end else begin
            rvalid_q <= req.rd;
            if (req.rd) begin
                rdata_q <= rdata_d;
            end
            advert_q <= adv_view;
        end
    end

    // -------------------------------------------------
    // Event counters
    // -------------------------------------------------
    ansc_event_counter #(.WIDTH(16)) u_disc (
        .clk(clk),
        .rst_n(rst_n),
        .soft_rst(soft_rst),
        .event_pulse(disconnect_event),
        .clear_rd(rd_dis),
        .count_q(disconnect_count_value)
    );
    ansc_event_counter #(.WIDTH(16)) u_fcar (
        .clk(clk),
        .rst_n(rst_n),
        .soft_rst(soft_rst),
        .event_pulse(false_carrier_event),
        .clear_rd(rd_fca),
        .count_q(false_carrier_count_value)
    );

    // -------------------------------------------------
    // Checks
    // -------------------------------------------------
    property p_pause_high;
        @(posedge clk) disable iff (!rst_n)
        rvalid_q && $past(hit_adv) |-> rdata_q[`ANSC_BIT_PAUSE];
    endproperty
    a_pause_high: assert property (p_pause_high) else $error("pause bit read as zero");

    property p_exp_zero;
        @(posedge clk) disable iff (!rst_n)
        rvalid_q && $past(hit_exp) |-> (rdata_q[15:5] == 11'h000);
    endproperty
    a_exp_zero: assert property (p_exp_zero) else $error("reserved expansion bits nonzero");

    property p_page_set;
        @(posedge clk) disable iff (!rst_n)
        page_valid && !soft_rst |=> page_rx_q && (partner_q == $past(page_word));
    endproperty
    a_page_set: assert property (p_page_set) else $error("page not captured");

    property p_page_clr;
        @(posedge clk) disable iff (!rst_n)
        rd_par && !page_valid |=> !page_rx_q;
    endproperty
    a_page_clr: assert property (p_page_clr) else $error("page flag not cleared by read");

    property p_soft;
        @(posedge clk) disable iff (!rst_n)
        soft_rst |=> (adv_store_q == `ANSC_ADVERT_RST) && (partner_q == 16'h0000) && !page_rx_q;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset left state");

    property p_ro_write;
        @(posedge clk) disable iff (!rst_n)
        req.wr && hit_adv && !soft_rst |=> (adv_store_q == ($past(req.wdata) & `ANSC_ADVERT_WMASK));
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("advert write wrong");

    // -------------------------------------------------
    // Read port and output word checks
    // -------------------------------------------------
    // Every read is answered on the next edge
    property p_rvalid_pulse;
        @(posedge clk) disable iff (!rst_n)
        req.rd && !soft_rst |=> rvalid_q;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read not answered");

    // No answer without a read
    property p_rvalid_idle;
        @(posedge clk) disable iff (!rst_n)
        !req.rd |=> !rvalid_q;
    endproperty
    a_rvalid_idle: assert property (p_rvalid_idle) else $error("answer without read");

    // Read data stands until the next read
    property p_rdata_hold;
        @(posedge clk) disable iff (!rst_n)
        !req.rd && !soft_rst |=> $stable(rdata_q);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    // Next page bit follows the engine level
    property p_adv_np;
        @(posedge clk) disable iff (!rst_n)
        !soft_rst |=> advert_q[`ANSC_BIT_NP] == $past(neg.next_page_flag);
    endproperty
    a_adv_np: assert property (p_adv_np) else $error("next page bit wrong");

    // Acknowledge bit follows the engine level
    property p_adv_ack;
        @(posedge clk) disable iff (!rst_n)
        !soft_rst |=> advert_q[`ANSC_BIT_ACK] == $past(neg.ack_sent);
    endproperty
    a_adv_ack: assert property (p_adv_ack) else $error("acknowledge bit wrong");

    // Pause support is always advertised
    property p_adv_pause_out;
        @(posedge clk) disable iff (!rst_n)
        advert_q[`ANSC_BIT_PAUSE];
    endproperty
    a_adv_pause_out: assert property (p_adv_pause_out) else $error("pause bit dropped");

    // Reserved advert bits 12, 11 and 9 never set
    property p_adv_reserved;
        @(posedge clk) disable iff (!rst_n)
        (advert_q & 16'h1A00) == 16'h0000;
    endproperty
    a_adv_reserved: assert property (p_adv_reserved) else $error("reserved advert bit set");

    // Selector read back as stored
    property p_adv_sel_read;
        @(posedge clk) disable iff (!rst_n)
        rvalid_q && $past(hit_adv) |-> rdata_q[4:0] == $past(adv_store_q[4:0]);
    endproperty
    a_adv_sel_read: assert property (p_adv_sel_read) else $error("selector read wrong");

    // Partner word read returns the latest page
    property p_par_read;
        @(posedge clk) disable iff (!rst_n)
        rvalid_q && $past(hit_par) |-> rdata_q == $past(partner_q);
    endproperty
    a_par_read: assert property (p_par_read) else $error("partner read wrong");

    // Expansion flags read as the live levels
    property p_exp_live;
        @(posedge clk) disable iff (!rst_n)
        rvalid_q && $past(hit_exp) |-> rdata_q[4:0] == {$past(neg.multiple_link_fault),
            $past(neg.partner_next_page_capable), $past(neg.local_next_page_capable),
            $past(page_rx_q), $past(neg.partner_negotiation_capable)};
    endproperty
    a_exp_live: assert property (p_exp_live) else $error("expansion flags wrong");

    // Unmapped offsets answer zero
    property p_unmapped;
        @(posedge clk) disable iff (!rst_n)
        rvalid_q && !$past(hit_any) |-> rdata_q == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

    // -------------------------------------------------
    // State retention, reset and counter read checks
    // -------------------------------------------------
    // Page flag holds without page or partner read
    property p_page_hold;
        @(posedge clk) disable iff (!rst_n)
        !page_valid && !rd_par && !soft_rst |=> page_rx_q == $past(page_rx_q);
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("page flag moved");

    // Partner word holds between pages
    property p_partner_hold;
        @(posedge clk) disable iff (!rst_n)
        !page_valid && !soft_rst |=> $stable(partner_q);
    endproperty
    a_partner_hold: assert property (p_partner_hold) else $error("partner word moved");

    // Advert store holds without a write to it
    property p_adv_hold;
        @(posedge clk) disable iff (!rst_n)
        !(req.wr && hit_adv) && !soft_rst |=> $stable(adv_store_q);
    endproperty
    a_adv_hold: assert property (p_adv_hold) else $error("advert store moved");

    // Hard reset sets the outputs to defaults
    property p_hard_rst;
        @(posedge clk)
        !rst_n |=> (rdata_q == 16'h0000) && !rvalid_q && (advert_q == `ANSC_ADVERT_RST);
    endproperty
    a_hard_rst: assert property (p_hard_rst) else $error("reset left outputs");

    // Software reset sets the outputs to defaults
    property p_soft_out;
        @(posedge clk) disable iff (!rst_n)
        soft_rst |=> (rdata_q == 16'h0000) && !rvalid_q && (advert_q == `ANSC_ADVERT_RST);
    endproperty
    a_soft_out: assert property (p_soft_out) else $error("soft reset left outputs");

    // Disconnect read returns the count before the clear
    property p_dis_read;
        @(posedge clk) disable iff (!rst_n)
        rvalid_q && $past(hit_dis) |-> rdata_q == $past(disconnect_count_value);
    endproperty
    a_dis_read: assert property (p_dis_read) else $error("disconnect read wrong");

    // False carrier read returns the count before the clear
    property p_fca_read;
        @(posedge clk) disable iff (!rst_n)
        rvalid_q && $past(hit_fca) |-> rdata_q == $past(false_carrier_count_value);
    endproperty
    a_fca_read: assert property (p_fca_read) else $error("false carrier read wrong");
endmodule // ansc_autoneg_bank

// >>> logic/ansc_defs.svh
// Constants for the auto-negotiation status and counter bank.
// Assumes a 16-bit register port inside the controller clock domain.
//
// Contract
// - Advert bit 15 next page, follows engine flag
// - Advert bit 14 set on acknowledge
// - Advert bit 13 remote fault writable, 0
// - Advert bit 10 pause reads 1
// - Advert bits 8..5 writable abilities, reset 1
// - Advert bits 4..0 selector, reset 00001
// - Partner bit 14 acknowledge from partner
// - Partner bit 13 partner remote fault
// - Partner bit 10 partner pause support
// - Partner bits 8..5 partner abilities, reset 0
// - Partner bits 4..0 selector, reset zeros
// - Expansion bits 15..5 read zero
// - Expansion bit 4 multiple link fault
// - Expansion bit 3 partner next page able
// - Expansion bit 2 local next page able
// - Expansion bit 1 set on page
// - Partner word read clears page flag
// - Expansion bit 0 partner negotiation capable
// - Disconnect counter counts, clears on read
// - Disconnect counter wraps, no saturation
// - False carrier counter counts, clears on read
// - Software reset restores all defaults
`ifndef ANSC_DEFS_SVH
`define ANSC_DEFS_SVH

// -------------------------------------------------
// Register offsets
// -------------------------------------------------
`define ANSC_OFF_ADVERT 8'h66
`define ANSC_OFF_PARTNER 8'h68
`define ANSC_OFF_EXPAN 8'h6A
`define ANSC_OFF_DISC 8'h6C
`define ANSC_OFF_FCAR 8'h6E

// -------------------------------------------------
// Field positions and reset values
// -------------------------------------------------
`define ANSC_BIT_NP 15
`define ANSC_BIT_ACK 14
`define ANSC_BIT_RF 13
`define ANSC_BIT_PAUSE 10
`define ANSC_ABIL_HI 8
`define ANSC_ABIL_LO 5
`define ANSC_SEL_HI 4
`define ANSC_SEL_LO 0
`define ANSC_ADVERT_WMASK 16'h21FF
`define ANSC_ADVERT_RST 16'h05E1
`define ANSC_PARTNER_RST 16'h0000
`define ANSC_EXPAN_MASK 16'h001F
`define ANSC_CNT_RST 16'h0000
`define ANSC_CNT_ONE 16'h0001

`endif

// >>> logic/ansc_pkg.sv
// Types shared by the auto-negotiation status bank.
// Assumes nothing beyond a SystemVerilog compiler.
package ansc_pkg;
    // Register port request from the controller
    typedef struct packed {
        logic rd;        // Read strobe
        logic wr;        // Write strobe
        logic [7:0] addr; // Byte offset
        logic [15:0] wdata; // Write data
    } ansc_req_s;
    // Status reported by the negotiation engine
    typedef struct packed {
        logic ack_sent;        // Local acknowledge in current page
        logic next_page_flag;  // Sending protocol page
        logic multiple_link_fault;
        logic partner_next_page_capable;
        logic local_next_page_capable;
        logic partner_negotiation_capable;
    } ansc_neg_s;
endpackage

// >>> logic/ansc_event_counter.sv
// Clear-on-read 16-bit event counter with wrap.
// Assumes event and read strobes are in the clk domain.
`timescale 1ns/1ns
`include "ansc_defs.svh"
module ansc_event_counter #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    input wire logic event_pulse,
    input wire logic clear_rd,
    output logic [WIDTH-1:0] count_q
);
    // -------------------------------------------------
    // Parameter check
    // -------------------------------------------------
    if (WIDTH != 16) begin : g_chk
        $error("ansc_event_counter supports only 16-bit counters");
    end

    // Next value: clear wins over old value, event still counted
    logic [WIDTH-1:0] count_d;
    logic [WIDTH-1:0] base;
    assign base = clear_rd ? WIDTH'(0) : count_q;
    assign count_d = event_pulse ? WIDTH'(base + WIDTH'(1)) : base;

    // -------------------------------------------------
    // Counter register
    // -------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            count_q <= WIDTH'(0);
        end else begin
            count_q <= count_d;
        end
    end

    // Clearing read with no event leaves zero
    property p_clear_zero;
        @(posedge clk) disable iff (!rst_n)
        (clear_rd && !event_pulse && !soft_rst) |=> (count_q == '0);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("counter not cleared by read");

    // Event during clear leaves exactly one
    property p_clear_keep;
        @(posedge clk) disable iff (!rst_n)
        (clear_rd && event_pulse && !soft_rst) |=> (count_q == WIDTH'(1));
    endproperty
    a_clear_keep: assert property (p_clear_keep) else $error("event lost during clearing read");

    // Plain event increments with wrap
    property p_incr;
        @(posedge clk) disable iff (!rst_n)
        (event_pulse && !clear_rd && !soft_rst) |=> (count_q == WIDTH'($past(count_q) + WIDTH'(1)));
    endproperty
    a_incr: assert property (p_incr) else $error("counter did not step by one");
endmodule // ansc_event_counter

// >>> tb/ansc_link_partner.sv
// Link-side model: negotiation levels, received pages and line events.
// Assumes the bench calls its tasks from the clk domain only.
`timescale 1ns/1ns
module ansc_link_partner (
    input wire logic clk,
    output ansc_pkg::ansc_neg_s neg,
    output logic page_valid,
    output logic [15:0] page_word,
    output logic disconnect_event,
    output logic false_carrier_event
);
    // -------------------------------------------------
    // Idle state
    // -------------------------------------------------
    initial begin
        neg = '0;
        page_valid = 1'b0;
        page_word = 16'h0000;
        disconnect_event = 1'b0;
        false_carrier_event = 1'b0;
    end
    // Live negotiation levels, changed just after an edge
    task automatic set_neg(input logic [5:0] v);
        @(posedge clk);
        neg <= v;
    endtask
    // One page; word lines carry junk outside the strobe so stale data never passes
    task automatic send_page(input logic [15:0] w);
        @(posedge clk);
        page_valid <= 1'b1;
        page_word <= w;
        @(posedge clk);
        page_valid <= 1'b0;
        page_word <= ~w;
    endtask
    // Back-to-back event pulses, one per cycle for n cycles
    task automatic pulse(input bit fc, input int n);
        @(posedge clk);
        if (fc) begin
            false_carrier_event <= 1'b1;
        end else begin
            disconnect_event <= 1'b1;
        end
        repeat (n) @(posedge clk);
        false_carrier_event <= 1'b0;
        disconnect_event <= 1'b0;
    endtask
endmodule // ansc_link_partner

// >>> tb/ansc_autoneg_bank_tb.sv
// Self-checking bench for the negotiation status and counter bank.
// Assumes the link model above drives every link-side input.
`timescale 1ns/1ns
module ansc_autoneg_bank_tb;
    logic clk;
    logic rst_n;
    logic soft_rst;
    ansc_pkg::ansc_req_s req; // Register port request
    ansc_pkg::ansc_neg_s neg; // Levels from link model
    logic page_valid;
    logic [15:0] page_word;
    logic disconnect_event;
    logic false_carrier_event;
    logic [15:0] rdata_q;
    logic rvalid_q;
    logic [15:0] advert_q;
    int error_cnt;
    int checks;

    ansc_autoneg_bank u_ansc_autoneg_bank (.clk(clk), .rst_n(rst_n), .soft_rst(soft_rst), .req(req), .neg(neg),
        .page_valid(page_valid), .page_word(page_word), .disconnect_event(disconnect_event),
        .false_carrier_event(false_carrier_event), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .advert_q(advert_q));
    ansc_link_partner u_ansc_link_partner (.clk(clk), .neg(neg), .page_valid(page_valid), .page_word(page_word),
        .disconnect_event(disconnect_event), .false_carrier_event(false_carrier_event));

    // -------------------------------------------------
    // Compare and bus tasks
    // -------------------------------------------------
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read strobe one cycle, answer looked at in the cycle it stands
    task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        cmp_bit(rvalid_q, 1'b1);
        cmp_word(rdata_q, exp);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // -------------------------------------------------
    // Scenarios
    // -------------------------------------------------
    task automatic t_defaults();
        reg_rd(8'h66, 16'h05E1);
        cmp_word(advert_q, 16'h05E1);
        reg_rd(8'h68, 16'h0000);
        reg_rd(8'h6A, 16'h0000);
        reg_rd(8'h6C, 16'h0000);
        reg_rd(8'h6E, 16'h0000);
        reg_rd(8'h70, 16'h0000); // Unmapped offset reads zero
    endtask
    // Read-only advert bits ignore writes; top bits follow the engine
    task automatic t_advert();
        reg_wr(8'h66, 16'hFFFF);
        reg_rd(8'h66, 16'h25FF);
        cmp_word(advert_q, 16'h25FF);
        reg_wr(8'h66, 16'h0000);
        reg_rd(8'h66, 16'h0400);
        reg_wr(8'h68, 16'hFFFF);
        reg_rd(8'h68, 16'h0000);
        u_ansc_link_partner.set_neg(6'h30);
        reg_rd(8'h66, 16'hC400);
        u_ansc_link_partner.set_neg(6'h00);
    endtask
    // One expansion flag at a time, so swapped bits show
    task automatic t_expansion();
        logic [3:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 4'h1 << i;
            u_ansc_link_partner.set_neg({2'b00, v});
            reg_rd(8'h6A, {11'h000, v[3], v[2], v[1], 1'b0, v[0]});
        end
        u_ansc_link_partner.set_neg(6'h00);
    endtask
    // Page flag set, cleared by partner read, set wins on a clash
    task automatic t_page();
        u_ansc_link_partner.send_page(16'hE5A1);
        reg_rd(8'h6A, 16'h0002);
        reg_rd(8'h68, 16'hE5A1);
        reg_rd(8'h6A, 16'h0000);
        fork
            reg_rd(8'h68, 16'hE5A1);
            u_ansc_link_partner.send_page(16'h2421);
        join
        reg_rd(8'h6A, 16'h0002);
        reg_rd(8'h68, 16'h2421);
    endtask
    // Counting, clear on read, wrap, and an event beside the clearing read
    task automatic t_counters();
        u_ansc_link_partner.pulse(1'b0, 3);
        reg_rd(8'h6C, 16'h0003);
        reg_rd(8'h6C, 16'h0000);
        u_ansc_link_partner.pulse(1'b0, 65537);
        reg_rd(8'h6C, 16'h0001);
        u_ansc_link_partner.pulse(1'b1, 5);
        fork
            reg_rd(8'h6E, 16'h0005);
            u_ansc_link_partner.pulse(1'b1, 1);
        join
        reg_rd(8'h6E, 16'h0001);
        reg_rd(8'h6E, 16'h0000);
    endtask
    // Software reset brings every register back to its default
    task automatic t_soft_reset();
        reg_wr(8'h66, 16'h0000);
        u_ansc_link_partner.pulse(1'b1, 2);
        u_ansc_link_partner.pulse(1'b0, 2);
        u_ansc_link_partner.send_page(16'hFFFF);
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        t_defaults();
    endtask

    // -------------------------------------------------
    // Verdict, clock, sequence and watchdog
    // -------------------------------------------------
    task automatic finish_test();
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        soft_rst = 1'b0;
        req = '0;
        error_cnt = 0;
        checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_defaults();
        t_advert();
        t_expansion();
        t_page();
        t_counters();
        t_soft_reset();
        finish_test();
    end
    // Run is about 66k cycles; 90k means a hang
    initial begin
        #900000;
        error_cnt++;
        finish_test();
    end
endmodule // ansc_autoneg_bank_tb
